/* File: shared/rvm_pkg.sv */
// Constants for the regulator output-voltage monitor
package rvm_pkg;
  localparam logic [8:0] RVM_ADDR_CTRL = 9'h114;
  localparam logic [8:0] RVM_ADDR_ENAB = 9'h115;
  localparam logic [7:0] RVM_CTRL_RESET = 8'h00;
  localparam logic [7:0] RVM_ENAB_RESET = 8'h00;
  localparam logic [7:0] RVM_ENAB_MASK = 8'hc4;
  localparam int RVM_DELAY_MSB = 7;
  localparam int RVM_DELAY_LSB = 6;
  localparam int RVM_MODE_MSB = 5;
  localparam int RVM_MODE_LSB = 4;
  localparam int RVM_DEB_BIT = 3;
  localparam int RVM_RES_BIT = 2;
  localparam int RVM_THR_MSB = 1;
  localparam int RVM_THR_LSB = 0;
  localparam int RVM_WATCH_THREE_BIT = 2;
  localparam int RVM_WATCH_SEVEN_BIT = 6;
  localparam int RVM_WATCH_EIGHT_BIT = 7;
  localparam logic [1:0] RVM_CHAN_THIRD = 2'h2;
  localparam int RVM_NREG = 3;
  localparam int RVM_VW = 8;
  localparam int RVM_THR_BASE_SHIFT = 2;
  localparam int RVM_RESET_HOLD_NS = 160;
  localparam int RVM_CLK_NS = 10;
  localparam int RVM_RESET_HOLD_CYC = RVM_RESET_HOLD_NS / RVM_CLK_NS;
  typedef enum logic [1:0] {
    RVM_MODE_LOCKOUT = 2'b00,
    RVM_MODE_NORMAL = 2'b01,
    RVM_MODE_BURST = 2'b10,
    RVM_MODE_RSVD = 2'b11
  } rvm_mode_t;
endpackage

/* File: core/rvm_range_check.sv */
// Window comparator for one measured regulator output
`timescale 1ns/100ps
module rvm_range_check #(
  parameter int VW = rvm_pkg::RVM_VW
) (
  input wire logic [VW-1:0] i_value,
  input wire logic [VW-1:0] i_target,
  input wire logic [1:0] i_thr_sel,
  output logic o_out_of_range
);
  import rvm_pkg::*;
  logic [VW-1:0] diff;
  logic [VW-1:0] limit;
  logic [2:0] shift;

  // Deviation magnitude and limit of target/4, /8, /16, /32
  assign diff = (i_value > i_target) ? i_value - i_target : i_target - i_value;
  assign shift = 3'(RVM_THR_BASE_SHIFT) + {1'b0, i_thr_sel};
  assign limit = i_target >> shift;
  assign o_out_of_range = diff > limit;
endmodule

/* File: core/rvm_monitor.sv */
// Regulator monitor control, event, shutdown and reset logic
`timescale 1ns/100ps
module rvm_monitor #(
  parameter int VW = rvm_pkg::RVM_VW,
  parameter int RESET_HOLD = rvm_pkg::RVM_RESET_HOLD_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [8:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_meas_valid,
  input wire logic [1:0] i_meas_chan,
  input wire logic [1:0] i_meas_reg,
  input wire logic [VW-1:0] i_meas_value,
  input wire logic [VW-1:0] i_target_three,
  input wire logic [VW-1:0] i_target_seven,
  input wire logic [VW-1:0] i_target_eight,
  input wire logic [rvm_pkg::RVM_NREG-1:0] i_reg_on,
  input wire logic i_event_clear,
  input wire logic i_range_fault_event_mask,
  output logic o_range_fault_event,
  output logic o_interrupt_out_n,
  output logic o_system_reset_out_n,
  output logic [rvm_pkg::RVM_NREG-1:0] o_reg_shutdown,
  output logic o_auto_normal,
  output logic o_auto_burst
);
  import rvm_pkg::*;

  logic [7:0] ctrl_r;
  logic [7:0] enab_r;
  logic [RVM_NREG-1:0] on_prev_r;
  logic [2:0] wait_r [RVM_NREG];
  logic [RVM_NREG-1:0] pend_r;
  logic [7:0] hold_r;
  logic [7:0] hold_nxt;
  logic event_nxt;

  rvm_mode_t mode;
  logic [1:0] delay_code;
  logic deb_en;
  logic res_en;
  logic [1:0] thr_sel;
  logic [RVM_NREG-1:0] watch;
  logic [VW-1:0] target_sel;
  logic oor;
  logic cand;
  logic hit;
  logic evt_set;
  logic wr_ctrl;
  logic wr_enab;
  logic [RVM_NREG-1:0] on_rise;
  logic [7:0] rd_mux;

  // Map a delay code to its count of skipped measurements
  function automatic logic [2:0] delay_count(input logic [1:0] code);
    case (code)
      2'b00: delay_count = 3'h0;
      2'b01: delay_count = 3'h1;
      2'b10: delay_count = 3'h2;
      default: delay_count = 3'h4;
    endcase
  endfunction

  // Field decode of the control and enable registers
  assign delay_code = ctrl_r[RVM_DELAY_MSB:RVM_DELAY_LSB];
  assign mode = rvm_mode_t'(ctrl_r[RVM_MODE_MSB:RVM_MODE_LSB]);
  assign deb_en = ctrl_r[RVM_DEB_BIT];
  assign res_en = ctrl_r[RVM_RES_BIT];
  assign thr_sel = ctrl_r[RVM_THR_MSB:RVM_THR_LSB];
  assign watch = {enab_r[RVM_WATCH_EIGHT_BIT], enab_r[RVM_WATCH_SEVEN_BIT],
                  enab_r[RVM_WATCH_THREE_BIT]};

  // Register port decode
  assign wr_ctrl = i_reg_wr && (i_reg_addr == RVM_ADDR_CTRL);
  assign wr_enab = i_reg_wr && (i_reg_addr == RVM_ADDR_ENAB);
  assign rd_mux = (i_reg_addr == RVM_ADDR_CTRL) ? ctrl_r :
                  (i_reg_addr == RVM_ADDR_ENAB) ? enab_r : 8'h00;

  // Target of the regulator being measured
  assign target_sel = (i_meas_reg == 2'h0) ? i_target_three :
                      (i_meas_reg == 2'h1) ? i_target_seven : i_target_eight;

  rvm_range_check #(.VW(VW)) u_check (
    .i_value(i_meas_value),
    .i_target(target_sel),
    .i_thr_sel(thr_sel),
    .o_out_of_range(oor)
  );

  // Qualified out-of-range candidate and debounced detection
  assign cand = i_meas_valid && (i_meas_reg < 2'(RVM_NREG)) && (mode == RVM_MODE_LOCKOUT)
                && watch[i_meas_reg] && i_reg_on[i_meas_reg]
                && (wait_r[i_meas_reg] == 3'h0) && oor;
  assign hit = cand && (!deb_en || pend_r[i_meas_reg]);
  assign on_rise = i_reg_on & ~on_prev_r;

  // Event sources per mode
  assign evt_set = hit
                   || (i_meas_valid && (mode == RVM_MODE_NORMAL))
                   || (i_meas_valid && (mode == RVM_MODE_BURST)
                       && (i_meas_chan == RVM_CHAN_THIRD));
  assign event_nxt = evt_set || (o_range_fault_event && !i_event_clear);

  // Reset output hold counter
  assign hold_nxt = (hit && res_en && i_range_fault_event_mask) ? 8'(RESET_HOLD) :
                    (hold_r != 8'h00) ? hold_r - 8'h01 : 8'h00;

  // Registers written by software
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_r <= RVM_CTRL_RESET;
      enab_r <= RVM_ENAB_RESET;
    end else begin
      if (wr_ctrl) ctrl_r <= i_reg_wdata;
      if (wr_enab) enab_r <= i_reg_wdata & RVM_ENAB_MASK;
    end
  end

  // Read data, mode outputs and status
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
      o_auto_normal <= 1'b0;
      o_auto_burst <= 1'b0;
      o_range_fault_event <= 1'b0;
      o_interrupt_out_n <= 1'b1;
    end else begin
      if (i_reg_rd) o_reg_rdata <= rd_mux;
      o_auto_normal <= (mode == RVM_MODE_NORMAL);
      o_auto_burst <= (mode == RVM_MODE_BURST);
      o_range_fault_event <= event_nxt;
      o_interrupt_out_n <= !(event_nxt && !i_range_fault_event_mask);
    end
  end

  // Start delay counters after regulator enable
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      on_prev_r <= '0;
      for (int k = 0; k < RVM_NREG; k++) wait_r[k] <= 3'h0;
    end else begin
      on_prev_r <= i_reg_on;
      for (int k = 0; k < RVM_NREG; k++) begin
        if (on_rise[k]) begin
          wait_r[k] <= delay_count(delay_code);
        end else if (i_meas_valid && (i_meas_reg == 2'(k)) && (wait_r[k] != 3'h0)) begin
          wait_r[k] <= wait_r[k] - 3'h1;
        end
      end
    end
  end

  // Debounce memory and regulator shutdown
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pend_r <= '0;
      o_reg_shutdown <= '0;
    end else begin
      for (int k = 0; k < RVM_NREG; k++) begin
        // A sample taken before the regulator went off must not count
        if (!i_reg_on[k]) begin
          pend_r[k] <= 1'b0;
        end else if (i_meas_valid && (i_meas_reg == 2'(k))) begin
          pend_r[k] <= cand;
        end
        if (hit && (i_meas_reg == 2'(k))) begin
          o_reg_shutdown[k] <= 1'b1;
        end else if (!i_reg_on[k]) begin
          o_reg_shutdown[k] <= 1'b0;
        end
      end
    end
  end

  // Active-low system reset output
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      hold_r <= 8'h00;
      o_system_reset_out_n <= 1'b1;
    end else begin
      hold_r <= hold_nxt;
      o_system_reset_out_n <= (hold_nxt == 8'h00);
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  sequence s_fault_reset;
    hit && res_en && i_range_fault_event_mask;
  endsequence

  chk_shutdown_on_fault: assert property (hit |=> o_reg_shutdown[$past(i_meas_reg)])
    else $error("regulator not shut down after fault");
  chk_irq_follows_flag: assert property (
    ##1 (o_interrupt_out_n == !(o_range_fault_event && !$past(i_range_fault_event_mask))))
    else $error("interrupt output does not follow event and mask");
  chk_set_beats_clear: assert property (evt_set && i_event_clear |=> o_range_fault_event)
    else $error("event lost against clear");
  chk_normal_event: assert property (
    i_meas_valid && mode == RVM_MODE_NORMAL |=> o_range_fault_event)
    else $error("normal mode measurement gave no event");
  chk_burst_event_slot: assert property (
    i_meas_valid && mode == RVM_MODE_BURST && i_meas_chan != RVM_CHAN_THIRD
    && !o_range_fault_event |=> !o_range_fault_event)
    else $error("burst event before third channel slot");
  chk_delay_blocks_fault: assert property (
    i_meas_valid && i_meas_reg < 2'(RVM_NREG) && wait_r[i_meas_reg] != 3'h0 |-> !hit)
    else $error("fault detected during start delay");
  chk_debounce_needs_two: assert property (deb_en && hit |-> pend_r[i_meas_reg])
    else $error("debounced fault on first sample");
  chk_reset_asserted: assert property (s_fault_reset |=> !o_system_reset_out_n [*2])
    else $error("reset output not held low after fault");
  chk_unwatched_quiet: assert property (
    i_meas_valid && i_meas_reg < 2'(RVM_NREG) && !watch[i_meas_reg] |-> !hit)
    else $error("fault on unwatched regulator");
  chk_no_reset_masked: assert property (
    !o_system_reset_out_n && $past(o_system_reset_out_n)
    |-> $past(res_en && i_range_fault_event_mask))
    else $error("reset output without reset enable");
endmodule

/* File: sim/tb_regulator_voltage_monitor.sv */
// Self-checking bench for the regulator output-voltage monitor
`timescale 1ns/100ps
module tb_regulator_voltage_monitor;
  import rvm_pkg::*;
  logic i_mclk = 1'b0, i_rst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_meas_valid = 1'b0;
  logic i_event_clear = 1'b0, i_range_fault_event_mask = 1'b0;
  logic [8:0] i_reg_addr = 9'h000;
  logic [7:0] i_reg_wdata = 8'h00, i_meas_value = 8'h00, o_reg_rdata;
  logic [7:0] i_target_three = 8'h64, i_target_seven = 8'h80, i_target_eight = 8'h80;
  logic [1:0] i_meas_chan = 2'h0, i_meas_reg = 2'h0;
  logic [2:0] i_reg_on = 3'h0, o_reg_shutdown;
  logic o_range_fault_event, o_interrupt_out_n, o_system_reset_out_n, o_auto_normal, o_auto_burst;
  int n_errors = 0, num_checks = 0;
  typedef struct {logic [8:0] a; logic [7:0] w; logic [7:0] e;} rvm_row_t;
  rvm_row_t rows[5];
  // Status byte: shutdown, normal, burst, event, interrupt_n, reset_n
  wire logic [7:0] st = {o_reg_shutdown, o_auto_normal, o_auto_burst, o_range_fault_event,
    o_interrupt_out_n, o_system_reset_out_n};

  rvm_monitor #(.RESET_HOLD(4)) dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .i_meas_valid(i_meas_valid), .i_meas_chan(i_meas_chan),
    .i_meas_reg(i_meas_reg), .i_meas_value(i_meas_value), .i_target_three(i_target_three),
    .i_target_seven(i_target_seven), .i_target_eight(i_target_eight), .i_reg_on(i_reg_on),
    .i_event_clear(i_event_clear), .i_range_fault_event_mask(i_range_fault_event_mask),
    .o_range_fault_event(o_range_fault_event), .o_interrupt_out_n(o_interrupt_out_n),
    .o_system_reset_out_n(o_system_reset_out_n), .o_reg_shutdown(o_reg_shutdown),
    .o_auto_normal(o_auto_normal), .o_auto_burst(o_auto_burst));

  // Clock generation
  initial begin
    forever #5 i_mclk = ~i_mclk;
  end

  // Compare and count
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  // Verdict and end of run
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Register bus cycles
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_mclk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] a);
    @(posedge i_mclk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_mclk);
    i_reg_rd <= 1'b0;
    @(negedge i_mclk);
  endtask

  // One finished measurement, sampled after the answer lands
  task automatic meas(input logic [1:0] c, input logic [1:0] r, input logic [7:0] v);
    @(posedge i_mclk);
    i_meas_valid <= 1'b1;
    i_meas_chan <= c;
    i_meas_reg <= r;
    i_meas_value <= v;
    @(posedge i_mclk);
    i_meas_valid <= 1'b0;
    @(negedge i_mclk);
  endtask

  // Regulator enables, then event clear and full off/on cycle
  task automatic ron(input logic [2:0] v);
    @(posedge i_mclk);
    i_reg_on <= v;
    @(negedge i_mclk);
  endtask
  task automatic recover();
    @(posedge i_mclk);
    i_event_clear <= 1'b1;
    @(posedge i_mclk);
    i_event_clear <= 1'b0;
    ron(3'h0);
    ron(3'h7);
  endtask

  // Hang guard
  initial begin
    #200000;
    n_errors++;
    end_of_test();
  end

  // Main sequence
  initial begin
    int lim;
    rows = '{'{9'h114, 8'hff, 8'hff}, '{9'h115, 8'hff, 8'hc4}, '{9'h113, 8'h5a, 8'h00},
      '{9'h114, 8'h00, 8'h00}, '{9'h115, 8'hc4, 8'hc4}};
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(negedge i_mclk);
    chk(st, 8'h03);
    rd(RVM_ADDR_CTRL);
    chk(o_reg_rdata, RVM_CTRL_RESET);
    chk({7'h00, o_reg_rdata[RVM_RES_BIT]}, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      chk(o_reg_rdata, rows[i].e);
    end
    ron(3'h7);
    meas(2'h0, 2'h0, 8'd125);
    chk(st, 8'h03);
    meas(2'h0, 2'h0, 8'd75);
    chk(st, 8'h03);
    meas(2'h0, 2'h0, 8'd74);
    chk(st, 8'h25);
    meas(2'h0, 2'h0, 8'd100);
    chk(st, 8'h25);
    recover();
    @(posedge i_mclk);
    i_range_fault_event_mask <= 1'b1;
    wr(RVM_ADDR_CTRL, 8'h04);
    meas(2'h0, 2'h0, 8'd200);
    chk(st, 8'h26);
    repeat (3) @(posedge i_mclk);
    @(negedge i_mclk);
    chk(st, 8'h26);
    @(negedge i_mclk);
    chk(st, 8'h27);
    @(posedge i_mclk);
    i_range_fault_event_mask <= 1'b0;
    wr(RVM_ADDR_CTRL, 8'h00);
    wr(RVM_ADDR_ENAB, 8'h80);
    recover();
    meas(2'h1, 2'h1, 8'd200);
    chk(st, 8'h03);
    meas(2'h1, 2'h2, 8'd200);
    chk(st, 8'h85);
    wr(RVM_ADDR_ENAB, 8'hc4);
    for (int k = 0; k < 4; k++) begin
      wr(RVM_ADDR_CTRL, 8'(k));
      recover();
      lim = 128 >> (2 + k);
      meas(2'h1, 2'h1, 8'(128 + lim));
      chk(st, 8'h03);
      meas(2'h1, 2'h1, 8'(127 - lim));
      chk(st, 8'h45);
    end
    for (int d = 0; d < 4; d++) begin
      wr(RVM_ADDR_CTRL, 8'(d << 6));
      recover();
      repeat ((d == 3) ? 4 : d) begin
        meas(2'h0, 2'h0, 8'd200);
        chk(st, 8'h03);
      end
      meas(2'h0, 2'h0, 8'd200);
      chk(st, 8'h25);
    end
    wr(RVM_ADDR_CTRL, 8'h08);
    recover();
    meas(2'h0, 2'h0, 8'd200);
    chk(st, 8'h03);
    meas(2'h0, 2'h0, 8'd100);
    meas(2'h0, 2'h0, 8'd200);
    chk(st, 8'h03);
    meas(2'h0, 2'h0, 8'd200);
    chk(st, 8'h25);
    wr(RVM_ADDR_CTRL, 8'h10);
    recover();
    meas(2'h1, 2'h3, 8'd0);
    chk(st, 8'h15);
    wr(RVM_ADDR_CTRL, 8'h20);
    recover();
    meas(2'h0, 2'h3, 8'd0);
    chk(st, 8'h0b);
    meas(2'h2, 2'h3, 8'd0);
    chk(st, 8'h0d);
    // Reset in mid-run clears flag, mode outputs and registers
    @(posedge i_mclk);
    i_rst <= 1'b1;
    @(posedge i_mclk);
    i_rst <= 1'b0;
    @(negedge i_mclk);
    chk(st, 8'h03);
    rd(RVM_ADDR_ENAB);
    chk(o_reg_rdata, RVM_ENAB_RESET);
    wr(RVM_ADDR_ENAB, 8'hc4);
    wr(RVM_ADDR_CTRL, 8'h30);
    recover();
    meas(2'h2, 2'h0, 8'd200);
    chk(st, 8'h03);
    end_of_test();
  end
endmodule
